// >>> inc/gpib_arm_cfg.svh
// Offsets, field positions, reset values and timing counts for the event-arm block
// Assumes a 4-bit word address and 16-bit data on the register port
`ifndef GPIB_ARM_CFG_SVH
`define GPIB_ARM_CFG_SVH

// ****************************************
// Register word offsets
// ****************************************
`define OFS_ARM        4'h0
`define OFS_CONFIG     4'h1
`define OFS_STATUS     4'h2
`define OFS_CLEAR      4'h3
`define OFS_IRQ_EN     4'h4
`define OFS_CONTROL    4'h5
`define OFS_BUS_STATE  4'h6

// ****************************************
// Arm mask bits
// ****************************************
`define ARM_W                    9
`define ADDRESS_CHANGE_ENABLE    8
`define CONTROL_GAINED_ENABLE    7
`define CONTROL_LOST_ENABLE      6
`define TRIGGER_RECEIVED_ENABLE  5
`define SERVICE_REQUEST_ENABLE   4
`define CLEAR_RECEIVED_ENABLE    3
`define LISTEN_ADDRESSED_ENABLE  2
`define TALK_ADDRESSED_ENABLE    1
`define UNADDRESSED_ENABLE       0

// ****************************************
// Status, config and control bits
// ****************************************
`define ST_W              4
`define ST_LIGHTPEN       0
`define ST_ADDR_CHANGE    1
`define ST_ABORT_DONE     2
`define ST_ABORT_REFUSED  3
`define CFG_LIGHTPEN_EN   0
`define CTRL_ABORT        0

// ****************************************
// Reset values
// ****************************************
`define ARM_RST     9'h000
`define LP_EN_RST   1'b0
`define ST_RST      4'h0
`define IRQ_EN_RST  4'h0

// ****************************************
// Bus command bytes and timing
// ****************************************
`define CMD_UNTALK    8'h5F
`define CMD_UNLISTEN  8'h3F
`define CLK_PERIOD_NS 100
`define IFC_HOLD_NS   100000
`define IFC_CYCLES    ((`IFC_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IFC_CNT_W     10

`endif

// >>> inc/gpib_arm_pkg.sv
// Types of the event-arm block and its abort sequencer
// Assumes gpib_arm_cfg.svh is on the include path
`include "gpib_arm_cfg.svh"
`default_nettype none

package gpib_arm_pkg;

	typedef enum logic [2:0] {
		ABORT_IDLE,
		ABORT_IFC,
		ABORT_ATN,
		ABORT_UNTALK,
		ABORT_UNLISTEN,
		ABORT_DONE
	} abort_state_t;

	typedef struct packed {
		logic [`ARM_W-1:0] arm;
		logic              lp_en;
		logic [`ST_W-1:0]  status;
		logic [`ST_W-1:0]  irq_en;
		logic              ctrl_q;
		logic              lsn_q;
		logic              tlk_q;
		logic              srq_q;
		logic              primed;
		logic [15:0]       rdata;
	} arm_state_t;

	typedef struct packed {
		abort_state_t          st;
		logic [`IFC_CNT_W-1:0] cnt;
		logic                  ifc;
		logic                  atn;
		logic [7:0]            cmd;
	} seq_state_t;

	localparam arm_state_t ARM_STATE_RST = '{
		arm:    `ARM_RST,
		lp_en:  `LP_EN_RST,
		status: `ST_RST,
		irq_en: `IRQ_EN_RST,
		ctrl_q: 1'b0,
		lsn_q:  1'b0,
		tlk_q:  1'b0,
		srq_q:  1'b0,
		primed: 1'b0,
		rdata:  16'h0000
	};

	localparam seq_state_t SEQ_STATE_RST = '{
		st:  ABORT_IDLE,
		cnt: '0,
		ifc: 1'b0,
		atn: 1'b0,
		cmd: 8'h00
	};

endpackage

`default_nettype wire

// >>> rtl/abort_seq.sv
// Bus abort sequencer: IFC pulse or ATN with untalk and unlisten
// Assumes start is a one-cycle pulse already qualified by controller role
`include "gpib_arm_cfg.svh"
`default_nettype none

module abort_seq (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 sys_rst,
	input  wire logic                 clk_en,
	// Request
	input  wire logic                 start,
	input  wire logic                 sys_ctrl,
	// Bus drive
	output logic                      ifc_assert,
	output logic                      atn_assert,
	output logic [7:0]                cmd_byte,
	output logic                      cmd_valid,
	input  wire logic                 cmd_ready,
	// Progress
	output logic                      busy,
	output logic                      done
);
	import gpib_arm_pkg::*;

	seq_state_t seq_r;
	seq_state_t seq_nxt;

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		seq_nxt = seq_r;
		case (seq_r.st)
			ABORT_IDLE: begin
				if (start && sys_ctrl) begin
					seq_nxt.st  = ABORT_IFC;
					seq_nxt.ifc = 1'b1;
					seq_nxt.cnt = `IFC_CNT_W'(`IFC_CYCLES - 1);
				end else if (start) begin
					seq_nxt.st  = ABORT_ATN;
					seq_nxt.atn = 1'b1;
				end
			end
			ABORT_IFC: begin
				if (seq_r.cnt == '0) begin
					seq_nxt.st  = ABORT_DONE;
					seq_nxt.ifc = 1'b0;
				end else begin
					seq_nxt.cnt = seq_r.cnt - `IFC_CNT_W'(1);
				end
			end
			ABORT_ATN: begin
				// One cycle of ATN alone before the first command byte
				seq_nxt.st  = ABORT_UNTALK;
				seq_nxt.cmd = `CMD_UNTALK;
			end
			ABORT_UNTALK: begin
				if (cmd_ready) begin
					seq_nxt.st  = ABORT_UNLISTEN;
					seq_nxt.cmd = `CMD_UNLISTEN;
				end
			end
			ABORT_UNLISTEN: begin
				if (cmd_ready) begin
					seq_nxt.st  = ABORT_DONE;
					seq_nxt.atn = 1'b0;
				end
			end
			ABORT_DONE: begin
				seq_nxt.st = ABORT_IDLE;
			end
			default: begin
				seq_nxt = SEQ_STATE_RST;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			seq_r <= SEQ_STATE_RST;
		end else if (clk_en) begin
			seq_r <= seq_nxt;
		end
	end

	assign ifc_assert = seq_r.ifc;
	assign atn_assert = seq_r.atn;
	assign cmd_byte   = seq_r.cmd;
	assign cmd_valid  = (seq_r.st == ABORT_UNTALK) || (seq_r.st == ABORT_UNLISTEN);
	assign busy       = (seq_r.st != ABORT_IDLE);
	assign done       = (seq_r.st == ABORT_DONE);

endmodule

`default_nettype wire

// >>> rtl/gpib_event_arm_abort.sv
// Event arming, lightpen attention status, interrupt and bus abort for a GPIB board
// Assumes role and addressing inputs come from the bus state logic on ref_clk
//
// What this block does
// - Arm bit 8 raises attention on any change of own address status.
// - Arm bit 8 alone covers control gain and loss, listen, talk and unaddressed changes.
// - Arm bit 7 raises attention when control passes to this board.
// - Arm bit 6 raises attention when this board hands control away.
// - Arm bit 5 raises attention on a trigger command received as peripheral.
// - Arm bit 4 raises attention when the internal service request bit sets.
// - Arm bit 3 raises attention on a clear command received as peripheral.
// - Arm bit 2 raises attention when addressed to listen as peripheral.
// - Arm bit 1 raises attention when addressed to talk as peripheral.
// - Arm bit 0 raises attention when unaddressed as talker and listener as peripheral.
// - Address conditions fire only on a real address change, shown by a status flag.
// - Attention is off after reset until configuration enables it.
// - Abort is taken only as active controller and idles every other device.
// - As active and system controller, abort pulses IFC.
// - As active non-system controller, abort asserts ATN then sends untalk and unlisten.
//
// Design decisions made here: the address map and strobed register access.
`include "gpib_arm_cfg.svh"
`default_nettype none

module gpib_event_arm_abort (
	// Clock, reset, enable
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [15:0]      reg_rdata,
	// Bus role and events
	input  wire logic        role_active_ctrl,
	input  wire logic        role_system_ctrl,
	input  wire logic        addr_listener,
	input  wire logic        addr_talker,
	input  wire logic        trigger_cmd_rx,
	input  wire logic        clear_cmd_rx,
	input  wire logic        service_req_bit,
	// Bus drive
	output logic             ifc_assert,
	output logic             atn_assert,
	output logic [7:0]       cmd_byte,
	output logic             cmd_valid,
	input  wire logic        cmd_ready,
	// Attention and interrupt
	output logic             lightpen_status,
	output logic             irq
);
	import gpib_arm_pkg::*;

	arm_state_t            cur_r;
	arm_state_t            cur_nxt;
	logic [`ARM_W-1:0]     evt;
	logic [`ARM_W-1:0]     hit;
	logic                  addr_chg;
	logic                  lp_set;
	logic                  wr_arm;
	logic                  wr_config;
	logic                  wr_clear;
	logic                  wr_irq_en;
	logic                  wr_control;
	logic                  rd_status;
	logic                  abort_req;
	logic                  abort_go;
	logic                  abort_refused;
	logic                  abort_busy;
	logic                  abort_done;
	logic [`ST_W-1:0]      st_set;
	logic [`ST_W-1:0]      st_clr;

	function automatic logic at_ofs(input logic [3:0] a, input logic [3:0] ofs);
		return a == ofs;
	endfunction

	// ****************************************
	// Register decode
	// ****************************************
	assign wr_arm     = reg_wr && at_ofs(reg_addr, `OFS_ARM);
	assign wr_config  = reg_wr && at_ofs(reg_addr, `OFS_CONFIG);
	assign wr_clear   = reg_wr && at_ofs(reg_addr, `OFS_CLEAR);
	assign wr_irq_en  = reg_wr && at_ofs(reg_addr, `OFS_IRQ_EN);
	assign wr_control = reg_wr && at_ofs(reg_addr, `OFS_CONTROL);
	assign rd_status  = reg_rd && at_ofs(reg_addr, `OFS_STATUS);

	// ****************************************
	// Event detection
	// ****************************************
	// Inputs seen before the first sampled cycle would fake edges, hence primed
	assign addr_chg = cur_r.primed &&
		({role_active_ctrl, addr_listener, addr_talker} !=
		 {cur_r.ctrl_q, cur_r.lsn_q, cur_r.tlk_q});

	assign evt[`ADDRESS_CHANGE_ENABLE] = addr_chg;
	assign evt[`CONTROL_GAINED_ENABLE] = addr_chg && role_active_ctrl
		&& !cur_r.ctrl_q;
	assign evt[`CONTROL_LOST_ENABLE] = addr_chg && !role_active_ctrl
		&& cur_r.ctrl_q;
	assign evt[`TRIGGER_RECEIVED_ENABLE] = cur_r.primed && trigger_cmd_rx
		&& !role_active_ctrl;
	assign evt[`SERVICE_REQUEST_ENABLE] = cur_r.primed && service_req_bit
		&& !cur_r.srq_q;
	assign evt[`CLEAR_RECEIVED_ENABLE] = cur_r.primed && clear_cmd_rx
		&& !role_active_ctrl;
	assign evt[`LISTEN_ADDRESSED_ENABLE] = addr_chg && !role_active_ctrl
		&& addr_listener && !cur_r.lsn_q;
	assign evt[`TALK_ADDRESSED_ENABLE] = addr_chg && !role_active_ctrl
		&& addr_talker && !cur_r.tlk_q;
	assign evt[`UNADDRESSED_ENABLE] = addr_chg && !role_active_ctrl
		&& !addr_listener && !addr_talker
		&& (cur_r.lsn_q || cur_r.tlk_q);

	genvar gi;
	generate
		for (gi = 0; gi < `ARM_W; gi++) begin : g_hit
			assign hit[gi] = evt[gi] && cur_r.arm[gi];
		end
	endgenerate

	assign lp_set = cur_r.lp_en && (|hit);

	// ****************************************
	// Abort request
	// ****************************************
	assign abort_req     = wr_control && reg_wdata[`CTRL_ABORT];
	// A request during a running abort is dropped, not queued
	assign abort_go      = abort_req && role_active_ctrl && !abort_busy;
	assign abort_refused = abort_req && !role_active_ctrl;

	abort_seq u_abort_seq (
		.ref_clk    (ref_clk),
		.sys_rst    (sys_rst),
		.clk_en     (clk_en),
		.start      (abort_go),
		.sys_ctrl   (role_system_ctrl),
		.ifc_assert (ifc_assert),
		.atn_assert (atn_assert),
		.cmd_byte   (cmd_byte),
		.cmd_valid  (cmd_valid),
		.cmd_ready  (cmd_ready),
		.busy       (abort_busy),
		.done       (abort_done)
	);

	// ****************************************
	// Sticky status
	// ****************************************
	always_comb begin
		st_set = '0;
		st_set[`ST_LIGHTPEN]      = lp_set;
		st_set[`ST_ADDR_CHANGE]   = addr_chg;
		st_set[`ST_ABORT_DONE]    = abort_done;
		st_set[`ST_ABORT_REFUSED] = abort_refused;
		st_clr = '0;
		if (wr_clear) begin
			st_clr = reg_wdata[`ST_W-1:0];
		end
		// Reading status acknowledges the attention bit only
		if (rd_status) begin
			st_clr[`ST_LIGHTPEN] = 1'b1;
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		cur_nxt        = cur_r;
		cur_nxt.primed = 1'b1;
		cur_nxt.ctrl_q = role_active_ctrl;
		cur_nxt.lsn_q  = addr_listener;
		cur_nxt.tlk_q  = addr_talker;
		cur_nxt.srq_q  = service_req_bit;
		// Set wins over clear in the same cycle
		cur_nxt.status = (cur_r.status & ~st_clr) | st_set;
		if (wr_arm) begin
			// Upper mask bits are expected zero and are not kept
			cur_nxt.arm = reg_wdata[`ARM_W-1:0];
		end
		if (wr_config) begin
			cur_nxt.lp_en = reg_wdata[`CFG_LIGHTPEN_EN];
		end
		if (wr_irq_en) begin
			cur_nxt.irq_en = reg_wdata[`ST_W-1:0];
		end
		cur_nxt.rdata = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				`OFS_ARM: begin
					cur_nxt.rdata[`ARM_W-1:0] = cur_r.arm;
				end
				`OFS_CONFIG: begin
					cur_nxt.rdata[`CFG_LIGHTPEN_EN] = cur_r.lp_en;
				end
				`OFS_STATUS: begin
					cur_nxt.rdata[`ST_W-1:0] = cur_r.status;
				end
				`OFS_IRQ_EN: begin
					cur_nxt.rdata[`ST_W-1:0] = cur_r.irq_en;
				end
				`OFS_BUS_STATE: begin
					cur_nxt.rdata[5:0] = {abort_busy, service_req_bit, addr_talker,
						addr_listener, role_system_ctrl, role_active_ctrl};
				end
				default: begin
					cur_nxt.rdata = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cur_r <= ARM_STATE_RST;
		end else if (clk_en) begin
			cur_r <= cur_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_rdata       = cur_r.rdata;
	assign lightpen_status = cur_r.status[`ST_LIGHTPEN];
	assign irq             = |(cur_r.status & cur_r.irq_en);

	// ****************************************
	// Assertions
	// ****************************************
	property p_unarmed_quiet;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && !lightpen_status && !(|hit) |=> !lightpen_status;
	endproperty
	a_unarmed_quiet: assert property (p_unarmed_quiet)
		else $error("attention set without an armed condition");

	property p_sticky;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && lightpen_status && !rd_status
			&& !(wr_clear && reg_wdata[`ST_LIGHTPEN]) |=> lightpen_status;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("attention dropped without read or clear");

	property p_disabled;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && !cur_r.lp_en && !lightpen_status |=> !lightpen_status;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("attention set while emulation disabled");

	property p_gain;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && cur_r.primed && cur_r.lp_en && cur_r.arm[`CONTROL_GAINED_ENABLE]
			&& role_active_ctrl && !cur_r.ctrl_q |=> lightpen_status;
	endproperty
	a_gain: assert property (p_gain)
		else $error("control gain did not raise attention");

	property p_trigger;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && cur_r.primed && cur_r.lp_en && cur_r.arm[`TRIGGER_RECEIVED_ENABLE]
			&& trigger_cmd_rx && !role_active_ctrl |=> lightpen_status;
	endproperty
	a_trigger: assert property (p_trigger)
		else $error("trigger as peripheral did not raise attention");

	property p_addr_flag;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && cur_r.primed && (addr_listener != cur_r.lsn_q)
			|=> cur_r.status[`ST_ADDR_CHANGE];
	endproperty
	a_addr_flag: assert property (p_addr_flag)
		else $error("address change flag not set");

	property p_refused;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && abort_req && !role_active_ctrl
			|=> !ifc_assert && !atn_assert && cur_r.status[`ST_ABORT_REFUSED];
	endproperty
	a_refused: assert property (p_refused)
		else $error("abort taken while not active controller");

	property p_ifc;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && abort_go && role_system_ctrl
			|=> ifc_assert && !atn_assert ##1 ifc_assert [*7];
	endproperty
	a_ifc: assert property (p_ifc)
		else $error("abort as system controller did not hold IFC");

	property p_atn_cmds;
		@(posedge ref_clk) disable iff (sys_rst)
		cmd_valid |-> atn_assert && !ifc_assert
			&& (cmd_byte == `CMD_UNTALK || cmd_byte == `CMD_UNLISTEN);
	endproperty
	a_atn_cmds: assert property (p_atn_cmds)
		else $error("command byte sent without ATN");

	property p_atn_start;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && abort_go && !role_system_ctrl
			|=> atn_assert && !cmd_valid ##1 !$past(clk_en) || (cmd_valid
			&& cmd_byte == `CMD_UNTALK);
	endproperty
	a_atn_start: assert property (p_atn_start)
		else $error("untalk did not follow ATN");

	property p_lost;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && cur_r.primed && cur_r.lp_en && cur_r.arm[`CONTROL_LOST_ENABLE]
			&& !role_active_ctrl && cur_r.ctrl_q |=> lightpen_status;
	endproperty
	a_lost: assert property (p_lost)
		else $error("control loss did not raise attention");

	property p_srq;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && cur_r.primed && cur_r.lp_en && cur_r.arm[`SERVICE_REQUEST_ENABLE]
			&& service_req_bit && !cur_r.srq_q |=> lightpen_status;
	endproperty
	a_srq: assert property (p_srq)
		else $error("service request did not raise attention");

	// IFC may only drop at the end of a finished abort
	property p_ifc_end;
		@(posedge ref_clk) disable iff (sys_rst)
		$fell(ifc_assert) |-> abort_done && !atn_assert;
	endproperty
	a_ifc_end: assert property (p_ifc_end)
		else $error("IFC released without finishing the abort");

	c_attention: cover property (@(posedge ref_clk) disable iff (sys_rst)
		$rose(lightpen_status));
	c_ifc: cover property (@(posedge ref_clk) disable iff (sys_rst)
		$fell(ifc_assert));
	c_unlisten: cover property (@(posedge ref_clk) disable iff (sys_rst)
		cmd_valid && cmd_ready && cmd_byte == `CMD_UNLISTEN);
	c_refused: cover property (@(posedge ref_clk) disable iff (sys_rst)
		abort_refused && clk_en);

endmodule

`default_nettype wire

// >>> verif/gpib_bus_partner.sv
// Model of the instruments on the bus: takes command bytes under ATN
// Assumes cmd_valid and cmd_byte come from the abort sequencer on ref_clk
`default_nettype none

module gpib_bus_partner (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	// Command handshake
	input  wire logic       cmd_valid,
	input  wire logic [7:0] cmd_byte,
	output logic            cmd_ready,
	// Model control and log
	input  wire logic [3:0] ready_delay,
	input  wire logic       log_clr,
	output logic [7:0]      rx_first,
	output logic [7:0]      rx_last,
	output logic [3:0]      rx_count
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [3:0] wait_cnt;

	// ****************************************
	// Acceptance after a programmable stall
	// ****************************************
	// Ready only while a byte is offered, so a slow listener really stalls
	assign cmd_ready = cmd_valid && (wait_cnt >= ready_delay);

	always_ff @(posedge ref_clk) begin
		if (sys_rst || log_clr) begin
			wait_cnt <= 4'h0;
			rx_count <= 4'h0;
			rx_first <= 8'h00;
			rx_last  <= 8'h00;
		end else if (cmd_valid && cmd_ready) begin
			wait_cnt <= 4'h0;
			rx_count <= rx_count + 4'h1;
			rx_last  <= cmd_byte;
			if (rx_count == 4'h0) begin
				rx_first <= cmd_byte;
			end
		end else if (cmd_valid) begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule

`default_nettype wire

// >>> verif/gpib_event_arm_abort_tb_top.sv
// Testbench: register port, event arming, interrupt and both abort paths
// Assumes the design include path and one 10 MHz clock
`include "gpib_arm_cfg.svh"
`default_nettype none

module gpib_event_arm_abort_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic        ref_clk     = 1'b0;
	logic        sys_rst     = 1'b1;
	logic        clk_en      = 1'b1;
	logic [3:0]  reg_addr    = 4'h0;
	logic [15:0] reg_wdata   = 16'h0000;
	logic        reg_wr      = 1'b0;
	logic        reg_rd      = 1'b0;
	logic        act         = 1'b0;
	logic        sys_ctl     = 1'b0;
	logic        lsn         = 1'b0;
	logic        tlk         = 1'b0;
	logic        trig        = 1'b0;
	logic        clr         = 1'b0;
	logic        srq         = 1'b0;
	logic [3:0]  ready_delay = 4'h0;
	logic        log_clr     = 1'b0;
	logic [15:0] reg_rdata;
	logic        ifc;
	logic        atn;
	logic        cmd_valid;
	logic        cmd_ready;
	logic        lightpen;
	logic        irq;
	logic [7:0]  cmd_byte;
	logic [7:0]  rx_first;
	logic [7:0]  rx_last;
	logic [3:0]  rx_count;
	logic [15:0] rd_val;
	int          n_mismatch  = 0;
	int          comparisons = 0;

	always #50 ref_clk = ~ref_clk;

	gpib_event_arm_abort dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .role_active_ctrl(act), .role_system_ctrl(sys_ctl),
		.addr_listener(lsn), .addr_talker(tlk), .trigger_cmd_rx(trig), .clear_cmd_rx(clr),
		.service_req_bit(srq), .ifc_assert(ifc), .atn_assert(atn), .cmd_byte(cmd_byte),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .lightpen_status(lightpen), .irq(irq));

	gpib_bus_partner partner_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
		.cmd_byte(cmd_byte), .cmd_ready(cmd_ready), .ready_delay(ready_delay),
		.log_clr(log_clr), .rx_first(rx_first), .rx_last(rx_last), .rx_count(rx_count));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic end_sim();
		$display("TB: %0d mismatches in %0d comparisons", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// Two settle cycles so every level change is seen as one event
	task automatic set_bus(input logic a, input logic l, input logic t);
		@(posedge ref_clk);
		act <= a;
		lsn <= l;
		tlk <= t;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask

	task automatic pulse_cmd(input logic is_trig);
		@(posedge ref_clk);
		trig <= is_trig;
		clr  <= !is_trig;
		@(posedge ref_clk);
		trig <= 1'b0;
		clr  <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic fire(input int b);
		case (b)
			8, 2: set_bus(1'b0, 1'b1, 1'b0);
			7: set_bus(1'b1, 1'b0, 1'b0);
			6, 0: set_bus(1'b0, 1'b0, 1'b0);
			5: pulse_cmd(1'b1);
			4: begin
				@(posedge ref_clk);
				srq <= 1'b1;
				repeat (2) @(posedge ref_clk);
				#1;
			end
			3: pulse_cmd(1'b0);
			default: set_bus(1'b0, 1'b0, 1'b1);
		endcase
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_reset();
		check({14'h0000, lightpen, irq}, 16'h0000);
		for (int i = 0; i < 7; i++) begin
			if (i != 3 && i != 5) begin
				reg_read(i[3:0], rd_val);
				check(rd_val, 16'h0000);
			end
		end
		reg_read(4'hF, rd_val);
		check(rd_val, 16'h0000);
		reg_write(`OFS_ARM, 16'h01FF);
		pulse_cmd(1'b1);
		check({15'h0000, lightpen}, 16'h0000);
		reg_read(`OFS_ARM, rd_val);
		check(rd_val, 16'h01FF);
		reg_write(`OFS_CONFIG, 16'h0001);
	endtask

	task automatic test_arm_table();
		for (int b = 8; b >= 0; b--) begin
			reg_write(`OFS_ARM, 16'h0000);
			srq <= 1'b0;
			set_bus(b == 6, b == 0, 1'b0);
			reg_write(`OFS_CLEAR, 16'h000F);
			reg_write(`OFS_ARM, 16'h0001 << b);
			fire(b);
			check({15'h0000, lightpen},
				16'h0001);
			reg_read(`OFS_STATUS, rd_val);
			check(rd_val, (b inside {8, 7, 6, 2, 1, 0}) ? 16'h0003 : 16'h0001);
			check({15'h0000, lightpen}, 16'h0000);
		end
	endtask

	task automatic test_masked();
		reg_write(`OFS_ARM, 16'h0000);
		reg_read(`OFS_ARM, rd_val);
		check(rd_val, 16'h0000);
		set_bus(1'b0, 1'b0, 1'b0);
		reg_write(`OFS_CLEAR, 16'h000F);
		pulse_cmd(1'b1);
		pulse_cmd(1'b0);
		set_bus(1'b0, 1'b1, 1'b0);
		check({15'h0000, lightpen}, 16'h0000);
		reg_write(`OFS_ARM, 16'h0100);
		set_bus(1'b0, 1'b1, 1'b0);
		check({15'h0000, lightpen}, 16'h0000);
		// Status is read-only: the address flag from the listen change stays
		reg_write(`OFS_STATUS, 16'h000F);
		reg_read(`OFS_STATUS, rd_val);
		check(rd_val, 16'h0002);
	endtask

	task automatic test_irq();
		reg_write(`OFS_ARM, 16'h0020);
		reg_write(`OFS_IRQ_EN, 16'h0001);
		pulse_cmd(1'b1);
		check({15'h0000, irq}, 16'h0001);
		reg_write(`OFS_IRQ_EN, 16'h0000);
		check({15'h0000, irq}, 16'h0000);
		reg_write(`OFS_IRQ_EN, 16'h0001);
		check({15'h0000, irq}, 16'h0001);
		// A frozen block must not take the clear
		clk_en <= 1'b0;
		reg_write(`OFS_CLEAR, 16'h0001);
		check({15'h0000, lightpen}, 16'h0001);
		clk_en <= 1'b1;
		reg_write(`OFS_CLEAR, 16'h0001);
		check({14'h0000, irq, lightpen}, 16'h0000);
	endtask

	task automatic test_abort_ifc();
		int n;
		sys_ctl <= 1'b1;
		set_bus(1'b1, 1'b0, 1'b0);
		reg_write(`OFS_CLEAR, 16'h000F);
		reg_write(`OFS_CONTROL, 16'h0001);
		check({15'h0000, ifc}, 16'h0001);
		// Busy, system and active; two IFC cycles spent on this read
		reg_read(`OFS_BUS_STATE, rd_val);
		check(rd_val, 16'h0023);
		n = 0;
		while (ifc === 1'b1 && n < 2000) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		check(n[15:0], 16'h03E6);
		check({15'h0000, atn}, 16'h0000);
		reg_read(`OFS_STATUS, rd_val);
		check(rd_val, 16'h0004);
	endtask

	task automatic test_abort_atn(input logic [3:0] dly);
		int n;
		sys_ctl     <= 1'b0;
		ready_delay <= dly;
		log_clr     <= 1'b1;
		set_bus(1'b1, 1'b0, 1'b0);
		log_clr <= 1'b0;
		reg_write(`OFS_CLEAR, 16'h000F);
		reg_write(`OFS_CONTROL, 16'h0001);
		check({14'h0000, atn, ifc}, 16'h0002);
		n = 0;
		while (rx_count !== 4'h2 && n < 100) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		check({rx_first, rx_last}, 16'h5F3F);
		check({14'h0000, atn, cmd_valid}, 16'h0000);
		reg_read(`OFS_STATUS, rd_val);
		check(rd_val, 16'h0004);
	endtask

	task automatic test_abort_refused();
		set_bus(1'b0, 1'b0, 1'b0);
		reg_write(`OFS_CLEAR, 16'h000F);
		reg_write(`OFS_CONTROL, 16'h0001);
		check({14'h0000, atn, ifc}, 16'h0000);
		reg_read(`OFS_STATUS, rd_val);
		check(rd_val, 16'h0008);
	endtask

	// ****************************************
	// Sequence and watchdog
	// ****************************************
	initial begin
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		test_reset();
		test_arm_table();
		test_masked();
		test_irq();
		test_abort_ifc();
		test_abort_atn(4'h0);
		test_abort_atn(4'h3);
		test_abort_refused();
		end_sim();
	end

	// Whole run is about 1260 cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		end_sim();
	end
endmodule

`default_nettype wire
